// >>> include/adc_ctl_defs.svh
// Register map, field positions and reset values of the converter control
//
// Overview of operation
// - Channel codes route to inputs, references, disable
// - Active bit 7 set on start, cleared on end
// - Software trigger: each status-one write, except one of the disable code, starts conversion
// - Hardware trigger: input rising edge starts conversion when idle, unless the disable code is selected and no status-one write falls in that cycle
// - Compare enable bit 5 turns compare on
// - Bit 4 selects less-than or greater-equal compare
// - Upper result holds bits 9:8, zero in 8-bit
// - Lower result holds low eight bits or all
// - Results load unless compare enabled and unmet
// - 10-bit upper read blocks loads until lower read
// - Result completing during interlock is discarded
// - 8-bit mode has no read interlock
// - Mode change invalidates both result registers
// - Pin bit n set disables digital I/O
`ifndef ADC_CTL_DEFS_SVH
`define ADC_CTL_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define OFS_STATUS_ONE  8'h00
`define OFS_STATUS_TWO  8'h04
`define OFS_RES_UPPER   8'h08
`define OFS_RES_LOWER   8'h0C
`define OFS_CMP_VALUE   8'h10
`define OFS_CONFIG      8'h14
`define OFS_PIN_LOW     8'h18
`define OFS_IRQ_STATUS  8'h1C
`define OFS_IRQ_MASK    8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_ACTIVE      7
`define BIT_TRIG_SEL    6
`define BIT_CMP_EN      5
`define BIT_CMP_GE      4
`define CH_MSB          4
`define BIT_MODE10      0
`define IRQ_DONE        0
`define IRQ_DROP        1

// ----------------------------------------------------------------------
// Channel codes
// ----------------------------------------------------------------------
`define CH_RESERVED     5'h1C
`define CH_VREFH        5'h1D
`define CH_VREFL        5'h1E
`define CH_OFF          5'h1F

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CHANNEL     5'h1F
`define RST_BYTE        8'h00

`endif

// >>> include/adc_ctl_pkg.sv
// Types shared by the converter control files
package adc_ctl_pkg;
  // Conversion sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} conv_state_e;
  // Decoded input class
  typedef enum logic [2:0] {SEL_PIN, SEL_VREFH, SEL_VREFL,
                            SEL_RSVD, SEL_OFF} input_class_e;
endpackage : adc_ctl_pkg

// >>> core/adc_channel_decode.sv
// Channel-select decoder for the converter input multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defs.svh"
module adc_channel_decode
  import adc_ctl_pkg::*;
(
  input  wire logic [4:0]          code,      // Channel select field
  output var adc_ctl_pkg::input_class_e in_class, // Kind of input chosen
  output logic [4:0]               pin_index  // Pin number when a pin
);
  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Pins pass straight through, including 8..15 and 24..27
  always_comb
  begin
    pin_index = code;
    case (code)
      `CH_VREFH:    in_class = SEL_VREFH;
      `CH_VREFL:    in_class = SEL_VREFL;
      `CH_RESERVED: in_class = SEL_RSVD;
      `CH_OFF:      in_class = SEL_OFF;
      default:      in_class = SEL_PIN;
    endcase
  end
endmodule : adc_channel_decode
`default_nettype wire

// >>> core/adc_control_result_logic.sv
// Converter control, result and register logic behind an APB slave
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defs.svh"
module adc_control_result_logic
  import adc_ctl_pkg::*;
#(
  parameter int PIN_COUNT = 8           // Pin-control bits in the low bank
)(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  hardware_trigger_in,
  input  wire logic                  core_done,     // Analog core finished
  input  wire logic [9:0]            core_result,   // Result with done
  output logic                       core_start,    // One-cycle start pulse
  output logic                       core_abort,    // One-cycle abort pulse
  output logic [4:0]                 core_channel,  // Pin index to convert
  output var adc_ctl_pkg::input_class_e core_class, // Input class to convert
  output logic                       core_mode10,   // 10-bit resolution
  output logic [PIN_COUNT-1:0]       pin_io_disable,// Digital I/O off per pin
  output logic                       irq
);
  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [4:0]            channel_select_r, channel_select_nxt; // Channel
  logic                  trigger_select_r, trigger_select_nxt; // HW trig
  logic                  compare_enable_r, compare_enable_nxt; // Compare on
  logic                  cmp_ge_r,         cmp_ge_nxt;         // Direction
  logic [9:0]            cmp_value_r,      cmp_value_nxt;      // Level
  logic                  mode10_r,         mode10_nxt;         // Resolution
  logic [PIN_COUNT-1:0]  pin_r,            pin_nxt;            // Pin ctl
  logic [9:0]            result_r,         result_nxt;         // Results
  logic                  lock_r,           lock_nxt;           // Interlock
  logic [1:0]            irq_stat_r,       irq_stat_nxt;       // Sticky
  logic [1:0]            irq_mask_r,       irq_mask_nxt;       // Mask
  conv_state_e           state_r,          state_nxt;          // Sequencer
  logic                  hw_prev_r,        hw_prev_nxt;        // Edge det
  logic                  start_r,          start_nxt;
  logic                  abort_r,          abort_nxt;
  logic [31:0]           prdata_r,         prdata_nxt;
  logic                  pready_r,         pready_nxt;
  logic                  pslverr_r,        pslverr_nxt;
  logic                  irq_r,            irq_nxt;

  // ----------------------------------------------------------------------
  // Bus strobes and decode
  // ----------------------------------------------------------------------
  // Access completes in the cycle after penable rises: one wait state
  logic       acc;           // Access phase, last cycle
  logic       wr;            // Write takes effect now
  logic       rd;            // Read takes effect now
  logic       mapped;        // Address hits a register
  logic       cmp_hit;       // Compare condition met
  logic       start_req;     // A trigger fired this cycle
  logic       wr_one;        // Write to status-one
  input_class_e dec_class;   // Decoded input kind
  logic [4:0] dec_pin;       // Decoded pin index

  assign acc = psel && penable && pready_r;
  assign wr  = acc && pwrite;
  assign rd  = acc && !pwrite;
  assign wr_one = wr && (paddr == `OFS_STATUS_ONE);

  always_comb
  begin
    case (paddr)
      `OFS_STATUS_ONE, `OFS_STATUS_TWO, `OFS_RES_UPPER, `OFS_RES_LOWER,
      `OFS_CMP_VALUE, `OFS_CONFIG, `OFS_PIN_LOW, `OFS_IRQ_STATUS,
      `OFS_IRQ_MASK: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  // Channel decoding shared with the analog side
  adc_channel_decode u_decode (
    .code      (channel_select_r),
    .in_class  (dec_class),
    .pin_index (dec_pin)
  );

  // ----------------------------------------------------------------------
  // Trigger and compare
  // ----------------------------------------------------------------------
  // A disabled channel code starts the core only on a hardware edge in its write cycle
  always_comb
  begin
    start_req = 1'b0;
    if (channel_select_r != `CH_OFF || wr_one)
    begin
      if (!trigger_select_r)
        start_req = wr_one && (pwdata[`CH_MSB:0] != `CH_OFF);
      else
        start_req = hardware_trigger_in && !hw_prev_r;
    end
  end

  // Compare tested on the completing result
  always_comb
  begin
    if (cmp_ge_r)
      cmp_hit = core_result >= cmp_value_r;
    else
      cmp_hit = core_result < cmp_value_r;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb
  begin
    channel_select_nxt = channel_select_r;
    trigger_select_nxt = trigger_select_r;
    compare_enable_nxt = compare_enable_r;
    cmp_ge_nxt         = cmp_ge_r;
    cmp_value_nxt      = cmp_value_r;
    mode10_nxt         = mode10_r;
    pin_nxt            = pin_r;
    result_nxt         = result_r;
    lock_nxt           = lock_r;
    irq_stat_nxt       = irq_stat_r;
    irq_mask_nxt       = irq_mask_r;
    state_nxt          = state_r;
    hw_prev_nxt        = hardware_trigger_in;
    start_nxt          = 1'b0;
    abort_nxt          = 1'b0;
    // Write-one-to-clear first so a same-cycle event below wins
    if (wr && paddr == `OFS_IRQ_STATUS)
      irq_stat_nxt = irq_stat_r & ~pwdata[1:0];
    // Register writes
    if (wr)
    begin
      case (paddr)
        `OFS_STATUS_ONE: channel_select_nxt = pwdata[`CH_MSB:0];
        `OFS_STATUS_TWO:
        begin
          // Bits 1:0 are left to software to write as zero
          trigger_select_nxt = pwdata[`BIT_TRIG_SEL];
          compare_enable_nxt = pwdata[`BIT_CMP_EN];
          cmp_ge_nxt         = pwdata[`BIT_CMP_GE];
        end
        `OFS_CMP_VALUE:  cmp_value_nxt = pwdata[9:0];
        `OFS_CONFIG:
        begin
          mode10_nxt = pwdata[`BIT_MODE10];
          if (pwdata[`BIT_MODE10] != mode10_r)
          begin
            result_nxt = 10'h000;
            lock_nxt   = 1'b0;
          end
        end
        `OFS_PIN_LOW:    pin_nxt = pwdata[PIN_COUNT-1:0];
        `OFS_IRQ_MASK:   irq_mask_nxt = pwdata[1:0];
        default:         ;
      endcase
    end
    // Interlock: upper read arms, lower read releases
    if (rd && paddr == `OFS_RES_UPPER && mode10_r)
      lock_nxt = 1'b1;
    if (rd && paddr == `OFS_RES_LOWER)
      lock_nxt = 1'b0;
    // Conversion sequencer
    case (state_r)
      ST_IDLE:
      begin
        if (start_req)
        begin
          start_nxt = 1'b1;
          state_nxt = ST_BUSY;
        end
      end
      ST_BUSY:
      begin
        if (wr_one || (wr && paddr == `OFS_CONFIG))
        begin
          // Rewrite of control aborts; a software write restarts
          abort_nxt = 1'b1;
          state_nxt = ST_IDLE;
          if (start_req)
          begin
            start_nxt = 1'b1;
            state_nxt = ST_BUSY;
          end
        end
        else if (core_done)
        begin
          state_nxt = ST_IDLE;
          if (!compare_enable_r || cmp_hit)
          begin
            if (lock_r && mode10_r)
              irq_stat_nxt[`IRQ_DROP] = 1'b1;
            else
            begin
              // 8-bit results keep bits 9:8 at zero
              result_nxt = mode10_r ? core_result
                                    : {2'b00, core_result[7:0]};
              irq_stat_nxt[`IRQ_DONE] = 1'b1;
            end
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  always_comb
  begin
    pready_nxt  = psel && penable && !pready_r;
    pslverr_nxt = psel && penable && !pready_r && !mapped;
    prdata_nxt  = 32'h0000_0000;
    irq_nxt     = |(irq_stat_nxt & irq_mask_nxt);
    if (psel && penable && !pready_r && !pwrite)
    begin
      case (paddr)
        `OFS_STATUS_ONE: prdata_nxt[`CH_MSB:0] = channel_select_r;
        `OFS_STATUS_TWO:
        begin
          prdata_nxt[`BIT_ACTIVE]   = (state_r == ST_BUSY);
          prdata_nxt[`BIT_TRIG_SEL] = trigger_select_r;
          prdata_nxt[`BIT_CMP_EN]   = compare_enable_r;
          prdata_nxt[`BIT_CMP_GE]   = cmp_ge_r;
        end
        `OFS_RES_UPPER:  prdata_nxt[1:0] = result_r[9:8];
        `OFS_RES_LOWER:  prdata_nxt[7:0] = result_r[7:0];
        `OFS_CMP_VALUE:  prdata_nxt[9:0] = cmp_value_r;
        `OFS_CONFIG:     prdata_nxt[`BIT_MODE10] = mode10_r;
        `OFS_PIN_LOW:    prdata_nxt[PIN_COUNT-1:0] = pin_r;
        `OFS_IRQ_STATUS: prdata_nxt[1:0] = irq_stat_r;
        `OFS_IRQ_MASK:   prdata_nxt[1:0] = irq_mask_r;
        default:         prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      channel_select_r <= `RST_CHANNEL;
      trigger_select_r <= 1'b0;
      compare_enable_r <= 1'b0;
      cmp_ge_r         <= 1'b0;
      cmp_value_r      <= 10'h000;
      mode10_r         <= 1'b0;
      pin_r            <= '0;
      result_r         <= 10'h000;
      lock_r           <= 1'b0;
      irq_stat_r       <= 2'h0;
      irq_mask_r       <= 2'h0;
      state_r          <= ST_IDLE;
      hw_prev_r        <= 1'b0;
      start_r          <= 1'b0;
      abort_r          <= 1'b0;
      prdata_r         <= 32'h0000_0000;
      pready_r         <= 1'b0;
      pslverr_r        <= 1'b0;
      irq_r            <= 1'b0;
    end
    else
    begin
      channel_select_r <= channel_select_nxt;
      trigger_select_r <= trigger_select_nxt;
      compare_enable_r <= compare_enable_nxt;
      cmp_ge_r         <= cmp_ge_nxt;
      cmp_value_r      <= cmp_value_nxt;
      mode10_r         <= mode10_nxt;
      pin_r            <= pin_nxt;
      result_r         <= result_nxt;
      lock_r           <= lock_nxt;
      irq_stat_r       <= irq_stat_nxt;
      irq_mask_r       <= irq_mask_nxt;
      state_r          <= state_nxt;
      hw_prev_r        <= hw_prev_nxt;
      start_r          <= start_nxt;
      abort_r          <= abort_nxt;
      prdata_r         <= prdata_nxt;
      pready_r         <= pready_nxt;
      pslverr_r        <= pslverr_nxt;
      irq_r            <= irq_nxt;
    end
  end

  // Channel and class lag the select by one cycle: both from flops
  logic [4:0]   chan_q_r;
  input_class_e class_q_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      chan_q_r  <= `RST_CHANNEL;
      class_q_r <= SEL_OFF;
    end
    else
    begin
      chan_q_r  <= dec_pin;
      class_q_r <= dec_class;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign core_start     = start_r;
  assign core_abort     = abort_r;
  assign core_channel   = chan_q_r;
  assign core_class     = class_q_r;
  assign core_mode10    = mode10_r;
  assign pin_io_disable = pin_r;
  assign irq            = irq_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_sw_start;
    @(posedge clk) disable iff (reset)
    (state_r == ST_IDLE && !trigger_select_r && wr_one
     && pwdata[`CH_MSB:0] != `CH_OFF) |=> core_start;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software write did not start");

  property p_hw_start;
    @(posedge clk) disable iff (reset)
    (state_r == ST_IDLE && trigger_select_r && !wr
     && channel_select_r != `CH_OFF && hardware_trigger_in
     && !hw_prev_r) |=> core_start ##0 (state_r == ST_BUSY);
  endproperty
  a_hw_start: assert property (p_hw_start)
    else $error("hardware trigger did not start");

  property p_active;
    @(posedge clk) disable iff (reset)
    core_start |-> state_r == ST_BUSY;
  endproperty
  a_active: assert property (p_active)
    else $error("active not set with start");

  property p_done_idle;
    @(posedge clk) disable iff (reset)
    (state_r == ST_BUSY && core_done && !wr) |=> state_r == ST_IDLE;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("active not cleared at completion");

  property p_no_trig_sw;
    @(posedge clk) disable iff (reset)
    (trigger_select_r && !wr_one && state_r == ST_IDLE
     && !(hardware_trigger_in && !hw_prev_r)) |=> !core_start;
  endproperty
  a_no_trig_sw: assert property (p_no_trig_sw)
    else $error("start without trigger");

  property p_cmp_keep;
    @(posedge clk) disable iff (reset)
    (state_r == ST_BUSY && core_done && !wr && compare_enable_r
     && !cmp_hit) |=> $stable(result_r);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep)
    else $error("result changed on failed compare");

  property p_load;
    @(posedge clk) disable iff (reset)
    (state_r == ST_BUSY && core_done && !wr && !compare_enable_r
     && !lock_r) |=> result_r[7:0] == $past(core_result[7:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("result not loaded");

  property p_eight_zero;
    @(posedge clk) disable iff (reset)
    (!mode10_r && !wr) |=> (!mode10_r) |-> result_r[9:8] == 2'b00;
  endproperty
  a_eight_zero: assert property (p_eight_zero)
    else $error("upper bits nonzero in 8-bit mode");

  property p_lock_drop;
    @(posedge clk) disable iff (reset)
    (lock_r && mode10_r && state_r == ST_BUSY && core_done && !wr)
    |=> $stable(result_r) ##0
        (irq_stat_r[`IRQ_DROP] || $past(compare_enable_r && !cmp_hit));
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("result stored during interlock");

  property p_no_lock8;
    @(posedge clk) disable iff (reset)
    !mode10_r && !lock_r && !wr |=> !lock_r;
  endproperty
  a_no_lock8: assert property (p_no_lock8)
    else $error("interlock armed in 8-bit mode");

  c_sw_conv:  cover property (@(posedge clk) core_start ##[1:50] core_done);
  c_lock:     cover property (@(posedge clk) lock_r ##1 !lock_r);
  c_drop:     cover property (@(posedge clk) irq_stat_r[`IRQ_DROP]);
  c_irq:      cover property (@(posedge clk) irq);
endmodule : adc_control_result_logic
`default_nettype wire

// >>> testbench/analog_core_model.sv
// Behavioural model of the analog conversion core
`timescale 1ns/1ps
`default_nettype none
module analog_core_model
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       core_start,
  input  wire logic       core_abort,
  input  wire logic [7:0] dly,         // Cycles from start to done
  input  wire logic [9:0] value,       // Result handed back
  output logic            core_done,
  output logic [9:0]      core_result
);
  // --------------------------------------------
  // Conversion timer
  // --------------------------------------------
  logic       busy;  // Conversion running
  logic [7:0] cnt;   // Cycles left
  // Result bus toggles outside done, so stale data never passes
  always_ff @(posedge clk)
  begin
    core_done   <= 1'b0;
    core_result <= reset ? 10'h000 : ~core_result;
    if (reset)
      busy <= 1'b0;
    else if (core_start)
    begin
      busy <= 1'b1;
      cnt  <= dly;
    end
    else if (core_abort)
      busy <= 1'b0;
    else if (busy && cnt == 8'h00)
    begin
      busy        <= 1'b0;
      core_done   <= 1'b1;
      core_result <= value;
    end
    else if (busy)
      cnt <= cnt - 8'h01;
  end
endmodule : analog_core_model
`default_nettype wire

// >>> testbench/adc_control_result_logic_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_defs.svh"
module adc_control_result_logic_tb;
  import adc_ctl_pkg::*;
  logic         clk = 1'b0, reset = 1'b1, hw = 1'b0, err;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00, dly = 8'h14, pin_io_disable;
  logic [31:0]  pwdata = 32'h0, rd, prdata;
  logic [9:0]   value = 10'h000, core_result;
  logic         pready, pslverr, core_done, core_start, core_abort;
  logic         core_mode10, irq;
  logic [4:0]   core_channel;
  input_class_e core_class;
  int           error_cnt = 0, comparisons = 0;
  always #50 clk = ~clk;
  // --------------------------------------------
  // Block and analog core
  // --------------------------------------------
  adc_control_result_logic DUT (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .hardware_trigger_in(hw),
    .core_done, .core_result, .core_start, .core_abort, .core_channel,
    .core_class, .core_mode10, .pin_io_disable, .irq);
  analog_core_model core (.clk, .reset, .core_start, .core_abort, .dly,
    .value, .core_done, .core_result);
  // --------------------------------------------
  // Shared tasks
  // --------------------------------------------
  task automatic give_verdict;
    $display("compares %0d, wrong %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // A used-up wait counts as a mismatch and ends the run
  task automatic bound(input bit hit);
    if (hit)
    begin
      error_cnt++;
      give_verdict;
    end
  endtask : bound
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    bound(n >= 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let registered outputs land before looking
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle
  task automatic wait_done;
    int n = 0;
    do @(posedge clk); while (core_done !== 1'b1 && ++n < 200);
    bound(n >= 200);
    settle;
  endtask : wait_done
  task automatic sw(input logic [9:0] v);
    value <= v;
    apb(1'b1, `OFS_STATUS_ONE, 32'h08);
    wait_done;
  endtask : sw
  task automatic hwc(input logic [9:0] v);
    @(posedge clk);
    value <= v;
    hw    <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
    wait_done;
  endtask : hwc
  task automatic res(input logic [31:0] up, input logic [31:0] lo);
    apb(1'b0, `OFS_RES_UPPER, 32'h0);
    chk(rd, up);
    apb(1'b0, `OFS_RES_LOWER, 32'h0);
    chk(rd, lo);
  endtask : res
  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task automatic t_regs;
    logic [4:0] c [8] = '{5'h08, 5'h0F, 5'h18, 5'h1B, 5'h1C, 5'h1D,
                          5'h1E, 5'h1F};
    input_class_e k [8] = '{SEL_PIN, SEL_PIN, SEL_PIN, SEL_PIN,
                            SEL_RSVD, SEL_VREFH, SEL_VREFL, SEL_OFF};
    apb(1'b0, `OFS_STATUS_TWO, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `OFS_PIN_LOW, 32'hA5);
    settle;
    chk(32'(pin_io_disable), 32'hA5);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, `OFS_STATUS_ONE, 32'(c[i]));
      @(negedge clk);
      chk(32'(core_start), 32'(i < 7));
      chk(32'(core_abort), 32'(i > 0));
      settle;
      chk(32'(core_class), 32'(k[i]));
      chk(32'(core_channel), 32'(c[i]));
    end
    apb(1'b0, `OFS_STATUS_TWO, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
  endtask : t_regs
  task automatic t_sw;
    apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
    value <= 10'h0A5;
    apb(1'b1, `OFS_STATUS_ONE, 32'h08);
    @(negedge clk);
    chk(32'(core_start), 32'h1);
    apb(1'b0, `OFS_STATUS_TWO, 32'h0);
    chk(rd, 32'h80);
    wait_done;
    apb(1'b0, `OFS_STATUS_TWO, 32'h0);
    chk(rd, 32'h0);
    res(32'h0, 32'hA5);
    chk(32'(irq), 32'h0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    settle;
    chk(32'(irq), 32'h1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    settle;
    chk(32'(irq), 32'h0);
    $display("test software trigger done");
  endtask : t_sw
  task automatic t_hw;
    apb(1'b1, `OFS_CONFIG, 32'h1);
    apb(1'b1, `OFS_CMP_VALUE, 32'h200);
    chk(32'(core_mode10), 32'h1);
    apb(1'b1, `OFS_STATUS_TWO, 32'h60);
    hwc(10'h300);
    res(32'h0, 32'h0);
    hwc(10'h1F0);
    res(32'h1, 32'hF0);
    apb(1'b1, `OFS_STATUS_TWO, 32'h70);
    hwc(10'h1FF);
    res(32'h1, 32'hF0);
    hwc(10'h250);
    res(32'h2, 32'h50);
    apb(1'b1, `OFS_STATUS_TWO, 32'h40);
    hwc(10'h100);
    res(32'h1, 32'h0);
    $display("test hardware trigger and compare done");
  endtask : t_hw
  task automatic t_lock;
    apb(1'b1, `OFS_STATUS_TWO, 32'h0);
    sw(10'h155);
    apb(1'b0, `OFS_RES_UPPER, 32'h0);
    chk(rd, 32'h1);
    sw(10'h2AA);
    apb(1'b0, `OFS_RES_LOWER, 32'h0);
    chk(rd, 32'h55);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    sw(10'h3CC);
    res(32'h3, 32'hCC);
    apb(1'b1, `OFS_CONFIG, 32'h0);
    res(32'h0, 32'h0);
    apb(1'b0, `OFS_RES_UPPER, 32'h0);
    sw(10'h0EE);
    res(32'h0, 32'hEE);
    $display("test read interlock done");
  endtask : t_lock
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_regs;
    t_sw;
    t_hw;
    t_lock;
    give_verdict;
  end
endmodule : adc_control_result_logic_tb
`default_nettype wire
